//--- include/remap_pkg.sv
// Package with offsets, fields, reset values and key codes for the code-area remap block.
package remap_pkg;

    localparam logic [11:0] ctrl_offset = 12'hfde;
    localparam logic [11:0] key_offset = 12'hfdf;
    localparam logic [11:0] flag_offset = 12'hfe0;
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam int rst_dis_bit = 0;
    localparam int ram_map_bit = 1;
    localparam int vec_ram_bit = 2;
    localparam logic [7:0] key_reset_dis = 8'hb2;
    localparam logic [7:0] key_map = 8'hd4;
    localparam logic [7:0] key_flag_clear = 8'h71;
    localparam logic [15:0] ram_code_lo = 16'h0040;
    localparam logic [15:0] ram_code_hi = 16'h083f;
    localparam logic [15:0] vcall_rom_base = 16'hffa0;
    localparam logic [15:0] vint_rom_base = 16'hffcc;
    localparam logic [15:0] vcall_ram_base = 16'h01a0;
    localparam logic [15:0] vint_ram_base = 16'h01cc;
    localparam logic [7:0] swi_opcode = 8'hff;
    localparam logic [1:0] axi_okay = 2'b00;
    localparam logic [1:0] axi_slverr = 2'b10;
endpackage

//--- core/vector_base_sel.sv
// Vector table base selector for vector calls and interrupts.
`timescale 1ns/1ps
module vector_base_sel
    import remap_pkg::*;
(
    input wire logic vec_ram,
    input wire logic [4:0] vcall_index,
    input wire logic [5:0] vint_index,
    output logic [15:0] vcall_addr,
    output logic [15:0] vint_addr
);
    always_comb begin
        if (vec_ram) begin
            vcall_addr = vcall_ram_base + {11'h000, vcall_index};
            vint_addr = vint_ram_base + {10'h000, vint_index};
        end else begin
            vcall_addr = vcall_rom_base + {11'h000, vcall_index};
            vint_addr = vint_rom_base + {10'h000, vint_index};
        end
    end
endmodule

//--- core/ram_code_area_remap.sv
// Code-area remap control with AXI4-Lite register access and fetch steering.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module ram_code_area_remap
    import remap_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_prog_mode,
    input wire logic [15:0] fetch_addr,
    input wire logic [7:0] flash_data,
    input wire logic [7:0] ram_data,
    output logic [7:0] fetch_data,
    output logic fetch_from_ram,
    input wire logic [4:0] vcall_index,
    input wire logic [5:0] vint_index,
    output logic [15:0] vcall_addr,
    output logic [15:0] vint_addr,
    output logic ram_code_map_state,
    output logic vector_ram_state,
    output logic reset_disable_ctl,
    output logic flag_clear_ctl
);
    // Staged control bits, committed mapping state and staged flag clear.
    logic [2:0] ctrl_reg;
    logic ram_map_reg;
    logic vec_ram_reg;
    logic rst_dis_reg;
    logic flag_stage_reg;
    logic flag_clear_reg;

    // Write and read channel holding registers.
    logic aw_held_reg;
    logic w_held_reg;
    logic [13:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    function automatic logic [11:0] word_addr(input logic [13:0] a);
        return a[13:2];
    endfunction

    function automatic logic mapped(input logic [11:0] w);
        return w == ctrl_offset || w == key_offset || w == flag_offset;
    endfunction

    logic do_write;
    logic [11:0] wr_word;
    assign wr_word = word_addr(awaddr_reg);
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 14'h0000;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= axi_okay;
        end else if (clk_en) begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= mapped(wr_word) ? axi_okay : axi_slverr;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    logic key_write;
    assign key_write = do_write && wstrb0_reg && wr_word == key_offset;

    // Staged bits change only by writes to the control or flag register.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= ctrl_reset[2:0];
            flag_stage_reg <= 1'b0;
        end else if (clk_en && do_write && wstrb0_reg) begin
            if (wr_word == ctrl_offset) begin
                ctrl_reg <= wdata_reg[2:0];
            end
            if (wr_word == flag_offset) begin
                flag_stage_reg <= wdata_reg[0];
            end
        end
    end

    // Committed state moves only on a matching key code.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ram_map_reg <= 1'b0;
            vec_ram_reg <= 1'b0;
            rst_dis_reg <= 1'b0;
            flag_clear_reg <= 1'b0;
        end else if (clk_en && key_write) begin
            case (wdata_reg)
                key_map: begin
                    ram_map_reg <= ctrl_reg[ram_map_bit];
                    vec_ram_reg <= ctrl_reg[vec_ram_bit];
                end
                key_reset_dis: begin
                    rst_dis_reg <= ctrl_reg[rst_dis_bit];
                end
                key_flag_clear: begin
                    flag_clear_reg <= flag_stage_reg;
                end
                default: begin
                    ram_map_reg <= ram_map_reg;
                end
            endcase
        end
    end

    // Read path: the key address reads back the committed relocation, mapping and reset-disable bits.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= axi_okay;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= mapped(word_addr(s_axi_araddr)) ? axi_okay : axi_slverr;
                case (word_addr(s_axi_araddr))
                    ctrl_offset: rdata_reg <= {29'h0, ctrl_reg};
                    key_offset: rdata_reg <= {29'h0, vec_ram_reg, ram_map_reg, rst_dis_reg};
                    flag_offset: rdata_reg <= {31'h0, flag_stage_reg};
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    logic ram_in_code;
    logic in_window;
    assign ram_in_code = ram_map_reg || serial_prog_mode;
    assign in_window = fetch_addr >= ram_code_lo && fetch_addr <= ram_code_hi;

    // Fetch steering for the RAM window.
    always_comb begin
        fetch_from_ram = 1'b0;
        fetch_data = flash_data;
        if (in_window) begin
            if (ram_in_code) begin
                fetch_from_ram = 1'b1;
                fetch_data = ram_data;
            end else begin
                fetch_data = swi_opcode;
            end
        end
    end

    vector_base_sel u_vec (
        .vec_ram(vec_ram_reg),
        .vcall_index(vcall_index),
        .vint_index(vint_index),
        .vcall_addr(vcall_addr),
        .vint_addr(vint_addr)
    );

    assign ram_code_map_state = ram_map_reg;
    assign vector_ram_state = vec_ram_reg;
    assign reset_disable_ctl = rst_dis_reg;
    assign flag_clear_ctl = flag_clear_reg;

    a_map_on_key: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && key_write && wdata_reg == key_map) |=> ram_map_reg == $past(ctrl_reg[ram_map_bit]))
        else $error("mapping not committed by key");
    a_stage_no_effect: assert property (@(posedge clk) disable iff (!reset_n)
        !(clk_en && key_write && wdata_reg == key_map) |=> $stable(ram_map_reg) && $stable(vec_ram_reg))
        else $error("mapping changed without key");
    a_other_key_keep: assert property (@(posedge clk) disable iff (!reset_n)
        (key_write && wdata_reg != key_map && wdata_reg != key_reset_dis && wdata_reg != key_flag_clear)
        |=> $stable(ram_map_reg) && $stable(rst_dis_reg) && $stable(flag_clear_reg))
        else $error("unknown key changed state");
    a_swi_fill: assert property (@(posedge clk) disable iff (!reset_n)
        (in_window && !ram_map_reg && !serial_prog_mode) |-> fetch_data == swi_opcode && !fetch_from_ram)
        else $error("unmapped window not swi");
    a_serial_map: assert property (@(posedge clk) disable iff (!reset_n)
        (in_window && serial_prog_mode) |-> fetch_from_ram)
        else $error("serial mode window not ram");
    a_vec_reloc: assert property (@(posedge clk) disable iff (!reset_n)
        vec_ram_reg |-> vcall_addr[15:8] == 8'h01 && vint_addr[15:8] == 8'h01)
        else $error("vectors not relocated");
    a_vec_rom: assert property (@(posedge clk) disable iff (!reset_n)
        !vec_ram_reg |-> vcall_addr[15:8] == 8'hff && vint_addr[15:8] == 8'hff)
        else $error("vectors not in rom");
    a_ctrl_upper: assert property (@(posedge clk) disable iff (!reset_n)
        (s_axi_rvalid && $past(word_addr(s_axi_araddr)) == ctrl_offset && $rose(s_axi_rvalid))
        |-> s_axi_rdata[7:3] == 5'h00)
        else $error("upper control bits not zero");
    a_status_read: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && s_axi_arvalid && s_axi_arready && word_addr(s_axi_araddr) == key_offset)
        |=> s_axi_rdata[2:1] == {$past(vec_ram_reg), $past(ram_map_reg)})
        else $error("status read mismatch");

    // The checks below cover each key code on its own, so a mix-up between codes shows up at once.

    // The first edge after reset must still see the RAM outside the code space.
    a_reset_unmapped: assert property (@(posedge clk) disable iff (!reset_n)
        !$past(reset_n)
        |-> !ram_map_reg && !vec_ram_reg)
        else $error("mapping active after reset");

    // The relocation bit is committed by the same key as the select bit.
    a_vec_on_key: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && key_write && wdata_reg == key_map)
        |=> vec_ram_reg == $past(ctrl_reg[vec_ram_bit]))
        else $error("relocation not committed by key");

    // The reset-disable bit follows only its own key.
    a_rst_dis_key: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && key_write && wdata_reg == key_reset_dis)
        |=> rst_dis_reg == $past(ctrl_reg[rst_dis_bit]))
        else $error("reset disable not committed by key");

    // Without its key the reset-disable bit must keep its value.
    a_rst_dis_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !(clk_en && key_write && wdata_reg == key_reset_dis)
        |=> $stable(rst_dis_reg))
        else $error("reset disable changed without key");

    // The flag-clear setting follows only its own key.
    a_flag_key: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && key_write && wdata_reg == key_flag_clear)
        |=> flag_clear_reg == $past(flag_stage_reg))
        else $error("flag clear not committed by key");

    // Without its key the flag-clear setting must keep its value.
    a_flag_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !(clk_en && key_write && wdata_reg == key_flag_clear)
        |=> $stable(flag_clear_reg))
        else $error("flag clear changed without key");

    // A mapped window must hand the RAM byte to the fetch unit.
    a_map_window: assert property (@(posedge clk) disable iff (!reset_n)
        (in_window && ram_map_reg)
        |-> fetch_from_ram && fetch_data == ram_data)
        else $error("mapped window not from ram");

    // Outside the window the fetch always comes from flash.
    a_outside_flash: assert property (@(posedge clk) disable iff (!reset_n)
        !in_window
        |-> !fetch_from_ram && fetch_data == flash_data)
        else $error("fetch outside window not flash");

    // Full vector-call address in the ROM table.
    a_vcall_rom: assert property (@(posedge clk) disable iff (!reset_n)
        !vec_ram_reg
        |-> vcall_addr == vcall_rom_base + {11'h000, vcall_index})
        else $error("vector call not in rom table");

    // Full interrupt vector address in the ROM table.
    a_vint_rom: assert property (@(posedge clk) disable iff (!reset_n)
        !vec_ram_reg
        |-> vint_addr == vint_rom_base + {10'h000, vint_index})
        else $error("interrupt vector not in rom table");

    // Full vector-call address in the RAM table.
    a_vcall_ram: assert property (@(posedge clk) disable iff (!reset_n)
        vec_ram_reg
        |-> vcall_addr == vcall_ram_base + {11'h000, vcall_index})
        else $error("vector call not in ram table");

    // Full interrupt vector address in the RAM table.
    a_vint_ram: assert property (@(posedge clk) disable iff (!reset_n)
        vec_ram_reg
        |-> vint_addr == vint_ram_base + {10'h000, vint_index})
        else $error("interrupt vector not in ram table");

    // A control write stages only the three defined bits.
    a_ctrl_stage: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && do_write && wstrb0_reg && wr_word == ctrl_offset)
        |=> ctrl_reg == $past(wdata_reg[2:0]))
        else $error("control write not staged");

    // Every read answer keeps the bits above the defined fields at zero.
    a_read_upper: assert property (@(posedge clk) disable iff (!reset_n)
        s_axi_rvalid
        |-> s_axi_rdata[31:3] == 29'h0)
        else $error("read upper bits not zero");

    // A write answer must stand until the master takes it.
    a_bvalid_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (s_axi_bvalid && !s_axi_bready)
        |=> s_axi_bvalid)
        else $error("write answer dropped early");
endmodule

//--- tb/ram_code_area_remap_tb_top.sv
// Self-checking testbench for the code-area remap block.
`timescale 1ns/1ps
module ram_code_area_remap_tb_top;
    import remap_pkg::*;
    typedef struct packed {logic [13:0] a; logic [7:0] d; logic [3:0] e;} row_t;
    logic clk = 0, reset_n = 0, clk_en = 1, serial_prog_mode = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [15:0] fetch_addr = 16'h0040, vcall_addr, vint_addr;
    logic [7:0] flash_data = 8'h3c, ram_data = 8'ha5, fetch_data;
    logic [4:0] vcall_index = 5'h1f;
    logic [5:0] vint_index = 6'h31;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fetch_from_ram;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ram_code_map_state, vector_ram_state, reset_disable_ctl, flag_clear_ctl;
    int num_errors = 0, checked = 0;
    logic [31:0] rv;
    logic [1:0] rs;
    // Both mapping bits are staged before the first 0xd4 commit, and the flag commits assume normal mode.
    row_t rows [9] = '{'{14'h3f78, 8'h06, 4'h0}, '{14'h3f7c, 8'h55, 4'h0}, '{14'h3f7c, 8'hd4, 4'h6},
        '{14'h3f78, 8'h01, 4'h6}, '{14'h3f7c, 8'h71, 4'h6}, '{14'h3f7c, 8'hb2, 4'h7},
        '{14'h3f80, 8'h01, 4'h7}, '{14'h3f7c, 8'h71, 4'hf}, '{14'h3f7c, 8'hd4, 4'h9}};

    ram_code_area_remap dut (.clk, .reset_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .serial_prog_mode, .fetch_addr, .flash_data, .ram_data,
        .fetch_data, .fetch_from_ram, .vcall_index, .vint_index, .vcall_addr, .vint_addr,
        .ram_code_map_state, .vector_ram_state, .reset_disable_ctl, .flag_clear_ctl);

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, m, g, e);
        end
    endtask

    // Handshakes are judged at the falling edge, where every ready has settled before the next rising edge.
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        logic aw, w, b;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        b = 0;
        while (!b) begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
            if (b) s_axi_bready <= 0;
        end
    endtask

    task automatic rd(input logic [13:0] a);
        logic ar, r;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        r = 0;
        while (!r) begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rv = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 0;
            if (r) s_axi_rready <= 0;
        end
    endtask

    task automatic results();
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        results();
    end

    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1;
        @(negedge clk);
        chk({ram_code_map_state, vector_ram_state, fetch_from_ram}, 3'b000, "reset map");
        chk(fetch_data, swi_opcode, "unmapped fetch");
        chk({vcall_addr, vint_addr}, {16'hffbf, 16'hfffd}, "rom vectors");
        rd(14'h3f78);
        chk(rv, {24'h0, ctrl_reset}, "control reset value");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            @(negedge clk);
            chk({flag_clear_ctl, vector_ram_state, ram_code_map_state, reset_disable_ctl}, rows[i].e, "row");
            rd(14'h3f7c);
            chk(rv, {29'h0, rows[i].e[2:0]}, "status read");
        end
        serial_prog_mode <= 1;
        @(negedge clk);
        chk({fetch_from_ram, fetch_data}, {1'b1, ram_data}, "serial mode fetch");
        chk(vcall_addr, 16'hffbf, "serial keeps rom vectors");
        serial_prog_mode <= 0;
        wr(14'h3f78, 8'hfe);
        rd(14'h3f78);
        chk(rv, 32'h6, "upper control bits");
        wr(14'h3f7c, 8'hd4);
        fetch_addr <= 16'h083f;
        @(negedge clk);
        chk({fetch_from_ram, fetch_data}, {1'b1, ram_data}, "window top");
        chk({vcall_addr, vint_addr}, {16'h01bf, 16'h01fd}, "ram vectors");
        fetch_addr <= 16'h0840;
        @(negedge clk);
        chk({fetch_from_ram, fetch_data}, {1'b0, flash_data}, "above window");
        fetch_addr <= 16'h003f;
        @(negedge clk);
        chk({fetch_from_ram, fetch_data}, {1'b0, flash_data}, "below window");
        rd(14'h0000);
        chk({rs, rv}, {axi_slverr, 32'h0}, "unmapped read");
        reset_n <= 0;
        repeat (2) @(posedge clk);
        reset_n <= 1;
        @(negedge clk);
        chk({flag_clear_ctl, vector_ram_state, ram_code_map_state, reset_disable_ctl}, 4'h0, "mid-run reset");
        rd(14'h3f78);
        chk(rv, 32'h0, "control after mid-run reset");
        results();
    end
endmodule
